// >>> shared/csr_defs.svh
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH

// Reverse-boost hold time in nanoseconds and the clock period it is counted in.
`define CSR_RB_HOLD_NS 1000000
`define CSR_CLK_PERIOD_NS 10
// Cycles of the hold time; a least time, so it rounds up.
`define CSR_RB_HOLD_CYC ((`CSR_RB_HOLD_NS + `CSR_CLK_PERIOD_NS - 1) / `CSR_CLK_PERIOD_NS)
`define CSR_RB_CNT_W 17
// Number of comparator and event inputs that pass through synchronisers.
`define CSR_SYNC_W 13

`endif

// >>> shared/csr_pkg.sv
`default_nettype none

package csr_pkg;
  // Charge-status tracking: first cycle, done or a recharge cycle, or idle.
  typedef enum logic [1:0] {
    CSR_STAT_IDLE,
    CSR_STAT_NEW,
    CSR_STAT_DONE,
    CSR_STAT_RECHARGE
  } csr_stat_e;

  // Reverse-boost prevention sequence.
  typedef enum logic [1:0] {
    CSR_RB_MONITOR,
    CSR_RB_HOLD,
    CSR_RB_RETEST
  } csr_rb_e;
endpackage : csr_pkg

`default_nettype wire

// >>> src/csr_ctrl.sv
// Behaviour
// - Converter stays in forced continuous conduction at every load, never discontinuous.
// - Reverse current without supplement trip: battery switch off, regulate system target 1 ms.
// - After 1 ms, battery switch back on and retest battery above regulation.
// - Protection enabled only between overvoltage threshold and regulation minus recharge offset.
// - Supplement-caused reverse boost may leave done; restart below regulation minus offset.
// - Supply-good low only inside lockout, sleep and overvoltage window; else released.
// - Charge-status low during new cycle, including thermistor or thermal suspension.
// - Battery reinsertion or input power toggle starts a new charge cycle.
// - Charge-status low until termination; early release on removal, timer fault, bad supply.
// - After new-cycle termination, charge-status released until the next new cycle.
// - Charge-status never low during recharge cycles after a termination.
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.svh"

module csr_ctrl (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic supply_above_uvlo_i,
  input wire logic supply_above_sleep_i,
  input wire logic supply_above_ovp_i,
  input wire logic battery_present_i,
  input wire logic bat_below_bovp_i,
  input wire logic bat_above_reg_i,
  input wire logic bat_above_rch_i,
  input wire logic reverse_current_i,
  input wire logic supplement_trip_i,
  input wire logic termination_i,
  input wire logic timer_fault_i,
  input wire logic thermistor_fault_i,
  input wire logic thermal_reg_i,
  output logic supply_good_flag_oe_n_o,
  output logic supply_good_flag_o,
  output logic charge_status_flag_oe_n_o,
  output logic charge_status_flag_o,
  output logic battery_switch_on_o,
  output logic fb_sysreg_o,
  output logic force_ccm_o,
  output logic charge_enable_o
);
  logic [`CSR_SYNC_W-1:0] raw_w;
  logic [`CSR_SYNC_W-1:0] s_w;

  assign raw_w = {supply_above_uvlo_i, supply_above_sleep_i, supply_above_ovp_i,
                  battery_present_i, bat_below_bovp_i, bat_above_reg_i, bat_above_rch_i,
                  reverse_current_i, supplement_trip_i, termination_i, timer_fault_i,
                  thermistor_fault_i, thermal_reg_i};

  // All comparator results come from the analog domain and are synchronised first.
  csr_sync u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(raw_w),
    .sync_o(s_w)
  );

  // Named views of the synchronised inputs.
  wire logic uvlo_ok_w = s_w[12];
  wire logic sleep_ok_w = s_w[11];
  wire logic ovp_w = s_w[10];
  wire logic bat_in_w = s_w[9];
  wire logic below_bovp_w = s_w[8];
  wire logic above_reg_w = s_w[7];
  wire logic above_rch_w = s_w[6];
  wire logic rev_w = s_w[5];
  wire logic supp_w = s_w[4];
  wire logic term_w = s_w[3];
  wire logic tfault_w = s_w[2];
  wire logic therm_w = s_w[1];
  wire logic thr_w = s_w[0];

  // Supply window: above lockout, above battery plus sleep offset, below overvoltage.
  wire logic supply_ok_w = uvlo_ok_w & sleep_ok_w & ~ovp_w;
  wire logic prot_window_w = below_bovp_w & above_rch_w;
  wire logic rb_trigger_w = prot_window_w & rev_w & ~supp_w;

  logic supply_ok_q;
  logic bat_in_q;
  // A supply that comes back valid or a battery that reappears opens a new cycle.
  wire logic new_cycle_w = (supply_ok_w & ~supply_ok_q) | (bat_in_w & ~bat_in_q);
  wire logic abort_w = ~bat_in_w | tfault_w | ~supply_ok_w;
  // Outside a recharge cycle, termination does not count while charging is suspended by heat.
  wire logic term_ok_w = term_w & ~therm_w & ~thr_w;

  csr_pkg::csr_stat_e stat_q;
  csr_pkg::csr_stat_e stat_d;
  csr_pkg::csr_rb_e rb_q;
  csr_pkg::csr_rb_e rb_d;
  logic [`CSR_RB_CNT_W-1:0] rb_cnt_q;
  logic [`CSR_RB_CNT_W-1:0] rb_cnt_d;
  logic supp_halt_q;
  logic supp_halt_d;

  localparam logic [`CSR_RB_CNT_W-1:0] RbLast = `CSR_RB_CNT_W'(`CSR_RB_HOLD_CYC - 1);

  // Charge-status sequence. Thermistor and thermal suspension keep a new cycle open.
  // An abort outranks a new-cycle edge, so the flag never blinks low while an abort condition holds.
  always_comb
  begin
    stat_d = stat_q;
    if (abort_w)
      stat_d = csr_pkg::CSR_STAT_IDLE;
    else if (new_cycle_w)
      stat_d = term_ok_w ? csr_pkg::CSR_STAT_DONE : csr_pkg::CSR_STAT_NEW;
    else
      case (stat_q)
        csr_pkg::CSR_STAT_NEW:
          if (term_ok_w)
            stat_d = csr_pkg::CSR_STAT_DONE;
        csr_pkg::CSR_STAT_DONE:
          if (~above_rch_w)
            stat_d = csr_pkg::CSR_STAT_RECHARGE;
        csr_pkg::CSR_STAT_RECHARGE:
          if (term_w)
            stat_d = csr_pkg::CSR_STAT_DONE;
        csr_pkg::CSR_STAT_IDLE:
          stat_d = csr_pkg::CSR_STAT_IDLE;
        default:
          stat_d = csr_pkg::CSR_STAT_IDLE;
      endcase
  end

  // Reverse-boost timer: hold for the full interval, then retest one cycle.
  always_comb
  begin
    rb_d = rb_q;
    rb_cnt_d = rb_cnt_q;
    case (rb_q)
      csr_pkg::CSR_RB_MONITOR:
        if (rb_trigger_w)
        begin
          rb_d = csr_pkg::CSR_RB_HOLD;
          rb_cnt_d = '0;
        end
      csr_pkg::CSR_RB_HOLD:
        if (rb_cnt_q == RbLast)
          rb_d = csr_pkg::CSR_RB_RETEST;
        else
          rb_cnt_d = rb_cnt_q + `CSR_RB_CNT_W'(1);
      csr_pkg::CSR_RB_RETEST:
        if (prot_window_w & above_reg_w & ~supp_w)
        begin
          rb_d = csr_pkg::CSR_RB_HOLD;
          rb_cnt_d = '0;
        end
        else
          rb_d = csr_pkg::CSR_RB_MONITOR;
      default:
        rb_d = csr_pkg::CSR_RB_MONITOR;
    endcase
  end

  // A supplement event while in reverse boost halts charging until the battery sags.
  always_comb
  begin
    supp_halt_d = supp_halt_q;
    if (rb_q != csr_pkg::CSR_RB_MONITOR && supp_w)
      supp_halt_d = 1'b1;
    else if (~above_rch_w)
      supp_halt_d = 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stat_q <= csr_pkg::CSR_STAT_IDLE;
      rb_q <= csr_pkg::CSR_RB_MONITOR;
      rb_cnt_q <= '0;
      supp_halt_q <= 1'b0;
      supply_ok_q <= 1'b0;
      bat_in_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      rb_q <= rb_d;
      rb_cnt_q <= rb_cnt_d;
      supp_halt_q <= supp_halt_d;
      supply_ok_q <= supply_ok_w;
      bat_in_q <= bat_in_w;
    end
  end

  // Registered outputs; enables are low while the pin is pulled down.
  wire logic rb_active_w = (rb_d == csr_pkg::CSR_RB_HOLD);
  wire logic stat_low_w = (stat_d == csr_pkg::CSR_STAT_NEW);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      supply_good_flag_oe_n_o <= 1'b1;
      supply_good_flag_o <= 1'b0;
      charge_status_flag_oe_n_o <= 1'b1;
      charge_status_flag_o <= 1'b0;
      battery_switch_on_o <= 1'b1;
      fb_sysreg_o <= 1'b0;
      force_ccm_o <= 1'b1;
      charge_enable_o <= 1'b0;
    end
    else
    begin
      supply_good_flag_oe_n_o <= ~supply_ok_w;
      supply_good_flag_o <= 1'b0;
      charge_status_flag_oe_n_o <= ~stat_low_w;
      charge_status_flag_o <= 1'b0;
      battery_switch_on_o <= ~rb_active_w;
      fb_sysreg_o <= rb_active_w;
      force_ccm_o <= 1'b1;
      charge_enable_o <= supply_ok_w & bat_in_w & ~therm_w & ~thr_w & ~tfault_w & ~supp_halt_d
                         & (stat_d == csr_pkg::CSR_STAT_NEW
                            || stat_d == csr_pkg::CSR_STAT_RECHARGE);
    end
  end
endmodule : csr_ctrl

`default_nettype wire

// >>> src/csr_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.svh"

// Two-flop synchroniser bank for asynchronous comparator and event inputs.
module csr_sync (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [`CSR_SYNC_W-1:0] async_i,
  output logic [`CSR_SYNC_W-1:0] sync_o
);
  logic [`CSR_SYNC_W-1:0] meta_q;
  logic [`CSR_SYNC_W-1:0] sync_q;

  // One generate entry per bit; the first stage feeds only the second.
  genvar gi;
  generate
    for (gi = 0; gi < `CSR_SYNC_W; gi = gi + 1)
    begin : g_bit
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end
        else
        begin
          meta_q[gi] <= async_i[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign sync_o = sync_q;
endmodule : csr_sync

`default_nettype wire

// >>> tb/charger_status_reverse_boost_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module charger_status_reverse_boost_ctrl_tb_top;
  logic clk_i, resetn_i, supply_above_uvlo_i, supply_above_sleep_i, supply_above_ovp_i;
  logic battery_present_i, bat_below_bovp_i, bat_above_reg_i, bat_above_rch_i, reverse_current_i;
  logic supplement_trip_i, termination_i, timer_fault_i, thermistor_fault_i, thermal_reg_i;
  logic supply_good_flag_oe_n_o, supply_good_flag_o, charge_status_flag_oe_n_o, charge_status_flag_o;
  logic battery_switch_on_o, fb_sysreg_o, force_ccm_o, charge_enable_o, good_pin, status_pin;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  // Rows of lockout, sleep, overvoltage and the expected level of the pin.
  logic [3:0] good_rows [5] = '{4'hF, 4'hC, 4'h9, 4'h5, 4'h1};

  csr_ctrl dut (.*);
  csr_status_pullups pullups (.good_oe_n_i(supply_good_flag_oe_n_o),
    .good_drive_i(supply_good_flag_o),
    .status_oe_n_i(charge_status_flag_oe_n_o), .status_drive_i(charge_status_flag_o),
    .good_pin_o(good_pin), .status_pin_o(status_pin));

  task automatic check(input string name, input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %b seen %b", name, exp, seen);
    end
  endtask : check

  // Three edges of latency plus one, then settle off the edge before looking.
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Free-running 100 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // The longest case is one full hold, so the ceiling sits a little above it.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 120000)
    begin
      mismatches++;
      end_sim();
    end
  end

  initial
  begin
    resetn_i = 1'b0;
    {supply_above_uvlo_i, supply_above_sleep_i, supply_above_ovp_i, battery_present_i} = 4'h0;
    {bat_below_bovp_i, bat_above_reg_i, bat_above_rch_i, reverse_current_i} = 4'h0;
    {supplement_trip_i, termination_i, timer_fault_i, thermistor_fault_i, thermal_reg_i} = 5'h0;
    step(10);
    check("reset_switch", battery_switch_on_o, 1'b1);
    check("reset_status", status_pin, 1'b1);
    resetn_i = 1'b1;
    foreach (good_rows[i])
    begin
      {supply_above_uvlo_i, supply_above_sleep_i, supply_above_ovp_i} = good_rows[i][3:1];
      step(4);
      check("good_pin", good_pin, good_rows[i][0]);
    end
    {battery_present_i, bat_below_bovp_i, bat_above_rch_i} = 3'h7;
    step(4);
    check("status_no_supply", status_pin, 1'b1);
    {supply_above_uvlo_i, supply_above_sleep_i} = 2'h3;
    step(4);
    check("status_power_on", status_pin, 1'b0);
    {thermistor_fault_i, termination_i} = 2'h3;
    step(4);
    check("status_therm_fault", status_pin, 1'b0);
    {thermistor_fault_i, thermal_reg_i} = 2'h1;
    step(4);
    check("status_thermal", status_pin, 1'b0);
    thermal_reg_i = 1'b0;
    step(4);
    check("status_done", status_pin, 1'b1);
    {termination_i, bat_above_rch_i} = 2'h0;
    step(4);
    check("status_recharge", status_pin, 1'b1);
    bat_above_rch_i = 1'b1;
    battery_present_i = 1'b0;
    step(4);
    battery_present_i = 1'b1;
    step(4);
    check("status_reinsert", status_pin, 1'b0);
    battery_present_i = 1'b0;
    step(4);
    check("status_removed", status_pin, 1'b1);
    battery_present_i = 1'b1;
    step(4);
    timer_fault_i = 1'b1;
    step(4);
    check("status_timer", status_pin, 1'b1);
    timer_fault_i = 1'b0;
    supply_above_ovp_i = 1'b1;
    step(4);
    check("good_ovp", good_pin, 1'b1);
    supply_above_ovp_i = 1'b0;
    {supplement_trip_i, reverse_current_i} = 2'h3;
    step(4);
    check("rb_supplement", battery_switch_on_o, 1'b1);
    {supplement_trip_i, bat_above_rch_i} = 2'h0;
    step(4);
    check("rb_window", battery_switch_on_o, 1'b1);
    bat_above_rch_i = 1'b1;
    step(4);
    reverse_current_i = 1'b0;
    check("rb_switch_off", battery_switch_on_o, 1'b0);
    check("rb_fb_sys", fb_sysreg_o, 1'b1);
    // A supplement trip inside the hold must stop charging until the battery sags.
    supplement_trip_i = 1'b1;
    step(4);
    supplement_trip_i = 1'b0;
    check("en_halted", charge_enable_o, 1'b0);
    step(99986);
    check("rb_still_held", fb_sysreg_o, 1'b1);
    step(20);
    check("rb_switch_back", battery_switch_on_o, 1'b1);
    check("rb_fb_back", fb_sysreg_o, 1'b0);
    check("en_still_halted", charge_enable_o, 1'b0);
    bat_above_rch_i = 1'b0;
    step(4);
    check("en_resumed", charge_enable_o, 1'b1);
    end_sim();
  end
endmodule : charger_status_reverse_boost_ctrl_tb_top

`default_nettype wire

// >>> tb/csr_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.svh"

module csr_ctrl_properties (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic supply_above_uvlo_i,
  input wire logic supply_above_sleep_i,
  input wire logic supply_above_ovp_i,
  input wire logic battery_present_i,
  input wire logic bat_below_bovp_i,
  input wire logic bat_above_reg_i,
  input wire logic bat_above_rch_i,
  input wire logic reverse_current_i,
  input wire logic supplement_trip_i,
  input wire logic termination_i,
  input wire logic timer_fault_i,
  input wire logic thermistor_fault_i,
  input wire logic thermal_reg_i,
  input wire logic supply_good_flag_oe_n_o,
  input wire logic supply_good_flag_o,
  input wire logic charge_status_flag_oe_n_o,
  input wire logic charge_status_flag_o,
  input wire logic battery_switch_on_o,
  input wire logic fb_sysreg_o,
  input wire logic force_ccm_o
);
  localparam int HOLD_CYC = `CSR_RB_HOLD_CYC;
  logic [1:0] settle_q;
  logic [`CSR_RB_CNT_W-1:0] hold_q;
  logic settled;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Delayed checks wait until the synchronisers hold samples taken after reset.
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) settle_q <= 2'h0;
    else if (settle_q != 2'h3) settle_q <= settle_q + 2'h1;
  // Length of the current hold, so its end can be tied to the exact count.
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) hold_q <= '0;
    else hold_q <= fb_sysreg_o ? hold_q + 1'b1 : '0;
  assign settled = settle_q == 2'h3;

  ccm_forced_a: assert property (force_ccm_o) else $error("converter left forced CCM");
  od_low_only_a: assert property (!supply_good_flag_o && !charge_status_flag_o)
    else $error("status pin drives high");
  good_window_a: assert property (settled |-> supply_good_flag_oe_n_o == !(
    $past(supply_above_uvlo_i, 3) && $past(supply_above_sleep_i, 3)
    && !$past(supply_above_ovp_i, 3))) else $error("supply good flag wrong");
  rb_entry_a: assert property (settled && $rose(fb_sysreg_o) |-> !$past(supplement_trip_i, 3)
    && $past(bat_below_bovp_i, 3) && $past(bat_above_rch_i, 3)
    && ($past(reverse_current_i, 3) || $past(bat_above_reg_i, 3))) else $error("bad hold entry");
  rb_hold_len_a: assert property ($fell(fb_sysreg_o) |-> hold_q == HOLD_CYC)
    else $error("hold length wrong");
  rb_switch_off_a: assert property (fb_sysreg_o |-> !battery_switch_on_o)
    else $error("switch on during hold");
  rb_switch_back_a: assert property ($fell(fb_sysreg_o) |-> battery_switch_on_o)
    else $error("switch not back on");
  status_abort_a: assert property (settled && (!$past(battery_present_i, 3)
    || $past(timer_fault_i, 3)) |-> charge_status_flag_oe_n_o)
    else $error("charge flag held on abort");
  status_term_a: assert property (settled && $past(termination_i, 3)
    && !$past(thermistor_fault_i, 3) && !$past(thermal_reg_i, 3) |-> charge_status_flag_oe_n_o)
    else $error("flag after termination");
  hold_seen_c: cover property ($fell(fb_sysreg_o));
  new_cycle_c: cover property ($fell(charge_status_flag_oe_n_o));
  supply_good_c: cover property ($fell(supply_good_flag_oe_n_o));
endmodule : csr_ctrl_properties

bind csr_ctrl csr_ctrl_properties csr_ctrl_props (.*);

`default_nettype wire

// >>> tb/csr_status_pullups.sv
`timescale 1ns/10ps
`default_nettype none

// Board side of the two status pins: each has a pull-up, so a released pin reads high.
module csr_status_pullups (
  input wire logic good_oe_n_i,
  input wire logic good_drive_i,
  input wire logic status_oe_n_i,
  input wire logic status_drive_i,
  output logic good_pin_o,
  output logic status_pin_o
);
  // An enabled pin shows the pull-down, never a stale level.
  assign good_pin_o = good_oe_n_i ? 1'b1 : good_drive_i;
  assign status_pin_o = status_oe_n_i ? 1'b1 : status_drive_i;
endmodule : csr_status_pullups

`default_nettype wire
